//--- inc/bcast_load_pkg.sv
// Constants for the broadcast and software load register logic.
package bcast_load_pkg;

  localparam int unsigned NUM_CH = 6;
  localparam int unsigned CODE_W = 14;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned LOW_W  = 6;
  localparam int unsigned BUS_W  = NUM_CH * CODE_W;

  // Register offsets on the device register port.
  localparam logic [7:0] ADDR_ACTIVE_LOW  = 8'h32;
  localparam logic [7:0] ADDR_ACTIVE_HIGH = 8'h33;
  localparam logic [7:0] ADDR_TARGETS     = 8'h34;
  localparam logic [7:0] ADDR_STAGE_LOW   = 8'h35;
  localparam logic [7:0] ADDR_STAGE_HIGH  = 8'h36;
  localparam logic [7:0] ADDR_TRANSFER    = 8'h37;

  // Field layout: low code bits sit at 7:2, reserved bits read zero.
  localparam int unsigned LOW_LSB    = 2;
  localparam int unsigned LOW_MSB    = 7;
  localparam int unsigned CH_MSB     = 5;
  localparam logic [1:0] RSVD_LOW   = 2'h0;
  localparam logic [1:0] RSVD_HIGH  = 2'h0;

  // Reset values.
  localparam logic [7:0]        RST_BYTE  = 8'h00;
  localparam logic [5:0]        RST_LOW   = 6'h00;
  localparam logic [NUM_CH-1:0] RST_CH    = 6'h00;
  localparam logic [CODE_W-1:0] RST_CODE  = 14'h0000;
  localparam logic [7:0]        READ_ZERO = 8'h00;

endpackage

//--- core/channel_load_slice.sv
// One channel of broadcast and software transfer strobes with code.
`timescale 1ns/1ps
module channel_load_slice
  import bcast_load_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  input  wire logic              target_i,
  input  wire logic              transfer_i,
  input  wire logic              act_bcast_i,
  input  wire logic              stg_bcast_i,
  input  wire logic [CODE_W-1:0] act_code_i,
  input  wire logic [CODE_W-1:0] staging_code_i,
  output logic                   staging_wr_o,
  output logic                   active_wr_o,
  output logic [CODE_W-1:0]      active_wdata_o
);

  logic              act_sel;
  logic              nxt_act_wr;
  logic [CODE_W-1:0] nxt_act_data;
  logic              staging_wr_ff;
  logic              active_wr_ff;
  logic [CODE_W-1:0] active_wdata_ff;

  // A broadcast and a transfer never share a cycle, since each comes
  // from its own register write; the broadcast is still given priority.
  assign act_sel      = target_i & act_bcast_i;
  assign nxt_act_wr   = act_sel | transfer_i;
  assign nxt_act_data = act_sel ? act_code_i : staging_code_i;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      staging_wr_ff   <= 1'b0;
      active_wr_ff    <= 1'b0;
      active_wdata_ff <= RST_CODE;
    end else begin
      staging_wr_ff   <= target_i & stg_bcast_i; // [RULE3] [RULE6]
      active_wr_ff    <= nxt_act_wr;             // [RULE1] [RULE8]
      if (nxt_act_wr) begin
        active_wdata_ff <= nxt_act_data;
      end
    end
  end

  assign staging_wr_o   = staging_wr_ff;
  assign active_wr_o    = active_wr_ff;
  assign active_wdata_o = active_wdata_ff;

endmodule

//--- core/dac_broadcast_and_soft_load.sv
// Broadcast code registers, channel targets and software transfer logic.
//
// Contract
// RULE1 - Active broadcast write copies code to targets
// RULE2 - Active broadcast high byte holds code 13:6
// RULE3 - Staging broadcast write copies code to targets
// RULE4 - Staging low byte 7:2 code, 1:0 zero
// RULE5 - Target mask has one bit per channel
// RULE6 - One target bit serves both broadcast paths
// RULE7 - Target bits 7:6 read zero, reset none
// RULE8 - Transfer bit copies staging code to active
// RULE9 - Transfer bits write-only and self-clearing
// RULE10 - Transfer register bits 5:0, reset zero
// RULE11 - Staging broadcast bytes reset to zero
// RULE12 - Active low byte 7:2 code, 1:0 zero
// RULE13 - Active code is fourteen bits per channel
// RULE14 - Staging code reaches output only when transferred
// RULE15 - Several transfer bits load in same cycle
// RULE16 - Broadcast uses full code after byte write
`timescale 1ns/1ps
module dac_broadcast_and_soft_load
  import bcast_load_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  output logic [7:0]             reg_rdata_o,
  input  wire logic [BUS_W-1:0]  staging_code_i,
  output logic [NUM_CH-1:0]      staging_wr_o,
  output logic [CODE_W-1:0]      staging_wdata_o,
  output logic [NUM_CH-1:0]      active_wr_o,
  output logic [BUS_W-1:0]       active_wdata_o
);

  logic              wr_act_lo;
  logic              wr_act_hi;
  logic              wr_targets;
  logic              wr_stg_lo;
  logic              wr_stg_hi;
  logic              wr_transfer;
  logic              rd_act_lo;
  logic              rd_act_hi;
  logic              rd_targets;
  logic              rd_stg_lo;
  logic              rd_stg_hi;
  logic [7:0]        nxt_rdata;
  logic [CODE_W-1:0] act_code;
  logic [CODE_W-1:0] stg_code;

  logic [LOW_W-1:0]  act_lo_ff;
  logic [7:0]        act_hi_ff;
  logic [LOW_W-1:0]  stg_lo_ff;
  logic [7:0]        stg_hi_ff;
  logic [NUM_CH-1:0] targets_ff;
  logic [NUM_CH-1:0] transfer_ff;
  logic              act_bcast_ff;
  logic              stg_bcast_ff;
  logic [CODE_W-1:0] stg_wdata_ff;
  logic [7:0]        rdata_ff;

  // Write and read decode of the register port.
  assign wr_act_lo   = reg_wr_i && (reg_addr_i == ADDR_ACTIVE_LOW);
  assign wr_act_hi   = reg_wr_i && (reg_addr_i == ADDR_ACTIVE_HIGH);
  assign wr_targets  = reg_wr_i && (reg_addr_i == ADDR_TARGETS);
  assign wr_stg_lo   = reg_wr_i && (reg_addr_i == ADDR_STAGE_LOW);
  assign wr_stg_hi   = reg_wr_i && (reg_addr_i == ADDR_STAGE_HIGH);
  assign wr_transfer = reg_wr_i && (reg_addr_i == ADDR_TRANSFER);
  assign rd_act_lo   = reg_rd_i && (reg_addr_i == ADDR_ACTIVE_LOW);
  assign rd_act_hi   = reg_rd_i && (reg_addr_i == ADDR_ACTIVE_HIGH);
  assign rd_targets  = reg_rd_i && (reg_addr_i == ADDR_TARGETS);
  assign rd_stg_lo   = reg_rd_i && (reg_addr_i == ADDR_STAGE_LOW);
  assign rd_stg_hi   = reg_rd_i && (reg_addr_i == ADDR_STAGE_HIGH);

  // Full codes are built from the stored bytes, so a broadcast one cycle
  // after either byte write already sees the new byte beside the old one.
  assign act_code = {act_hi_ff, act_lo_ff}; // [RULE16] [RULE13]
  assign stg_code = {stg_hi_ff, stg_lo_ff}; // [RULE16] [RULE14]

  // Read mux; the transfer register and unmapped offsets read as zero.
  always_comb begin
    if (rd_act_lo) begin
      nxt_rdata = {act_lo_ff, RSVD_LOW}; // [RULE12]
    end else if (rd_act_hi) begin
      nxt_rdata = act_hi_ff; // [RULE2]
    end else if (rd_targets) begin
      nxt_rdata = {RSVD_HIGH, targets_ff}; // [RULE7]
    end else if (rd_stg_lo) begin
      nxt_rdata = {stg_lo_ff, RSVD_LOW}; // [RULE4]
    end else if (rd_stg_hi) begin
      nxt_rdata = stg_hi_ff; // [RULE4]
    end else begin
      nxt_rdata = READ_ZERO; // [RULE9] [RULE10]
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      act_lo_ff <= RST_LOW;
      act_hi_ff <= RST_BYTE;
    end else begin
      if (wr_act_lo) begin
        act_lo_ff <= reg_wdata_i[LOW_MSB:LOW_LSB]; // [RULE12]
      end
      if (wr_act_hi) begin
        act_hi_ff <= reg_wdata_i; // [RULE2]
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stg_lo_ff <= RST_LOW;  // [RULE11]
      stg_hi_ff <= RST_BYTE; // [RULE11]
    end else begin
      if (wr_stg_lo) begin
        stg_lo_ff <= reg_wdata_i[LOW_MSB:LOW_LSB]; // [RULE4]
      end
      if (wr_stg_hi) begin
        stg_hi_ff <= reg_wdata_i; // [RULE4]
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      targets_ff <= RST_CH;
    end else if (wr_targets) begin
      targets_ff <= reg_wdata_i[CH_MSB:0]; // [RULE5] [RULE7]
    end
  end

  // Transfer bits live for exactly one cycle after their write, which
  // makes them self-clearing and lets all set channels load together.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      transfer_ff <= RST_CH;
    end else if (wr_transfer) begin
      transfer_ff <= reg_wdata_i[CH_MSB:0]; // [RULE8] [RULE15]
    end else begin
      transfer_ff <= RST_CH; // [RULE9] [RULE10]
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      act_bcast_ff <= 1'b0;
      stg_bcast_ff <= 1'b0;
    end else begin
      act_bcast_ff <= wr_act_lo | wr_act_hi; // [RULE1]
      stg_bcast_ff <= wr_stg_lo | wr_stg_hi; // [RULE3]
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stg_wdata_ff <= RST_CODE;
      rdata_ff     <= READ_ZERO;
    end else begin
      if (stg_bcast_ff) begin
        stg_wdata_ff <= stg_code; // [RULE3]
      end
      rdata_ff <= nxt_rdata;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      channel_load_slice u_slice (
        .sys_clk_i      (sys_clk_i),
        .rst_i          (rst_i),
        .target_i       (targets_ff[ch]),
        .transfer_i     (transfer_ff[ch]),
        .act_bcast_i    (act_bcast_ff),
        .stg_bcast_i    (stg_bcast_ff),
        .act_code_i     (act_code),
        .staging_code_i (staging_code_i[ch*CODE_W +: CODE_W]),
        .staging_wr_o   (staging_wr_o[ch]),
        .active_wr_o    (active_wr_o[ch]),
        .active_wdata_o (active_wdata_o[ch*CODE_W +: CODE_W])
      );
    end
  endgenerate

  assign staging_wdata_o = stg_wdata_ff;
  assign reg_rdata_o     = rdata_ff;

  // Assertion helper: channel 0 and channel 5 slices of the buses.
  logic [CODE_W-1:0] act_out_0;
  logic [CODE_W-1:0] stg_in_0;
  logic [CODE_W-1:0] act_out_5;
  assign act_out_0 = active_wdata_o[0 +: CODE_W];
  assign stg_in_0  = staging_code_i[0 +: CODE_W];
  assign act_out_5 = active_wdata_o[(NUM_CH-1)*CODE_W +: CODE_W];

  property p_act_bcast;
    @(posedge sys_clk_i) disable iff (rst_i)
    (wr_act_hi || wr_act_lo) |-> ##2
      (active_wr_o == $past(targets_ff, 1));
  endproperty
  a_act_bcast: assert property (p_act_bcast) // [RULE1]
    else $error("active broadcast strobes do not follow targets");

  property p_act_bcast_code;
    @(posedge sys_clk_i) disable iff (rst_i)
    (act_bcast_ff && targets_ff[NUM_CH-1]) |=>
      (active_wr_o[NUM_CH-1] && act_out_5 == $past(act_code));
  endproperty
  a_act_bcast_code: assert property (p_act_bcast_code) // [RULE16]
    else $error("active broadcast carries wrong code");

  property p_act_hi_read;
    @(posedge sys_clk_i) disable iff (rst_i)
    (wr_act_hi ##1 (rd_act_hi && !reg_wr_i)) |=>
      (reg_rdata_o == $past(reg_wdata_i, 2));
  endproperty
  a_act_hi_read: assert property (p_act_hi_read) // [RULE2]
    else $error("active high byte read back differs");

  property p_stg_bcast;
    @(posedge sys_clk_i) disable iff (rst_i)
    stg_bcast_ff |=> (staging_wr_o == $past(targets_ff)) &&
      (staging_wdata_o == $past(stg_code));
  endproperty
  a_stg_bcast: assert property (p_stg_bcast) // [RULE3]
    else $error("staging broadcast strobes or code wrong");

  property p_stg_lo_read;
    @(posedge sys_clk_i) disable iff (rst_i)
    rd_stg_lo |=> (reg_rdata_o[LOW_LSB-1:0] == RSVD_LOW) &&
      (reg_rdata_o[LOW_MSB:LOW_LSB] == $past(stg_lo_ff));
  endproperty
  a_stg_lo_read: assert property (p_stg_lo_read) // [RULE4]
    else $error("staging low byte read layout wrong");

  property p_act_lo_read;
    @(posedge sys_clk_i) disable iff (rst_i)
    rd_act_lo |=> (reg_rdata_o[LOW_LSB-1:0] == RSVD_LOW) &&
      (reg_rdata_o[LOW_MSB:LOW_LSB] == $past(act_lo_ff));
  endproperty
  a_act_lo_read: assert property (p_act_lo_read) // [RULE12]
    else $error("active low byte read layout wrong");

  property p_targets_read;
    @(posedge sys_clk_i) disable iff (rst_i)
    (wr_targets ##1 rd_targets) |=>
      (reg_rdata_o == {RSVD_HIGH, $past(reg_wdata_i[CH_MSB:0], 2)});
  endproperty
  a_targets_read: assert property (p_targets_read) // [RULE7]
    else $error("target register read back wrong");

  property p_no_target_quiet;
    @(posedge sys_clk_i) disable iff (rst_i)
    (act_bcast_ff && targets_ff == RST_CH) |=> (active_wr_o == RST_CH);
  endproperty
  a_no_target_quiet: assert property (p_no_target_quiet) // [RULE5]
    else $error("unselected channel loaded by broadcast");

  property p_stg_no_target_quiet;
    @(posedge sys_clk_i) disable iff (rst_i)
    (stg_bcast_ff && targets_ff == RST_CH) |=> (staging_wr_o == RST_CH);
  endproperty
  a_stg_no_target_quiet: assert property (p_stg_no_target_quiet) // [RULE5]
    else $error("unselected channel staged by broadcast");

  // Without a broadcast flag or a set transfer bit no channel may load.
  property p_idle_quiet;
    @(posedge sys_clk_i) disable iff (rst_i)
    (!act_bcast_ff && transfer_ff == RST_CH) |=> (active_wr_o == RST_CH);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) // [RULE8]
    else $error("active strobe without broadcast or transfer");

  property p_transfer;
    @(posedge sys_clk_i) disable iff (rst_i)
    (wr_transfer && reg_wdata_i[0]) |-> ##2
      (active_wr_o[0] && act_out_0 == $past(stg_in_0));
  endproperty
  a_transfer: assert property (p_transfer) // [RULE8]
    else $error("transfer did not load staging code");

  property p_transfer_all;
    @(posedge sys_clk_i) disable iff (rst_i)
    wr_transfer |-> ##2 (active_wr_o == $past(reg_wdata_i[CH_MSB:0], 2));
  endproperty
  a_transfer_all: assert property (p_transfer_all) // [RULE15]
    else $error("transfer channels did not load together");

  property p_self_clear;
    @(posedge sys_clk_i) disable iff (rst_i)
    wr_transfer ##1 !wr_transfer |=> (transfer_ff == RST_CH);
  endproperty
  a_self_clear: assert property (p_self_clear) // [RULE9]
    else $error("transfer bits did not clear");

  property p_transfer_read;
    @(posedge sys_clk_i) disable iff (rst_i)
    (reg_rd_i && reg_addr_i == ADDR_TRANSFER) |=> (reg_rdata_o == READ_ZERO);
  endproperty
  a_transfer_read: assert property (p_transfer_read) // [RULE10]
    else $error("transfer register did not read zero");

endmodule

//--- verification/code_bank_model.sv
// Behavioural bank of per-channel staging and active codes.
`timescale 1ns/1ps
module code_bank_model
  import bcast_load_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  input  wire logic [NUM_CH-1:0] staging_wr_i,
  input  wire logic [CODE_W-1:0] staging_wdata_i,
  input  wire logic [NUM_CH-1:0] active_wr_i,
  input  wire logic [BUS_W-1:0]  active_wdata_i,
  output logic      [BUS_W-1:0]  staging_code_o,
  output logic      [BUS_W-1:0]  active_code_o
);
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      staging_code_o <= '0;
      active_code_o  <= '0;
    end else begin
      for (int n = 0; n < NUM_CH; n++) begin
        if (staging_wr_i[n]) begin
          staging_code_o[n*CODE_W +: CODE_W] <= staging_wdata_i;
        end
        if (active_wr_i[n]) begin
          active_code_o[n*CODE_W +: CODE_W] <=
            active_wdata_i[n*CODE_W +: CODE_W];
        end
      end
    end
  end
endmodule

//--- verification/test_dac_broadcast_and_soft_load.sv
// Self-checking bench for broadcast and software transfer registers.
`timescale 1ns/1ps
module test_dac_broadcast_and_soft_load
  import bcast_load_pkg::*;
;
  logic                sys_clk_i;
  logic                rst_i;
  logic                reg_wr_i;
  logic                reg_rd_i;
  logic [7:0]          reg_addr_i;
  logic [7:0]          reg_wdata_i;
  logic [7:0]          reg_rdata_o;
  logic [BUS_W-1:0]    staging_code_i;
  logic [NUM_CH-1:0]   staging_wr_o;
  logic [CODE_W-1:0]   staging_wdata_o;
  logic [NUM_CH-1:0]   active_wr_o;
  logic [BUS_W-1:0]    active_wdata_o;
  logic [BUS_W-1:0]    active_code;
  logic [2*NUM_CH-1:0] strobes;
  int                  n_mismatch;
  int                  tests_run;

  assign strobes = {staging_wr_o, active_wr_o};

  dac_broadcast_and_soft_load dut (
    .sys_clk_i      (sys_clk_i),
    .rst_i          (rst_i),
    .reg_wr_i       (reg_wr_i),
    .reg_rd_i       (reg_rd_i),
    .reg_addr_i     (reg_addr_i),
    .reg_wdata_i    (reg_wdata_i),
    .reg_rdata_o    (reg_rdata_o),
    .staging_code_i (staging_code_i),
    .staging_wr_o   (staging_wr_o),
    .staging_wdata_o(staging_wdata_o),
    .active_wr_o    (active_wr_o),
    .active_wdata_o (active_wdata_o)
  );

  code_bank_model bank (
    .sys_clk_i      (sys_clk_i),
    .rst_i          (rst_i),
    .staging_wr_i   (staging_wr_o),
    .staging_wdata_i(staging_wdata_o),
    .active_wr_i    (active_wr_o),
    .active_wdata_i (active_wdata_o),
    .staging_code_o (staging_code_i),
    .active_code_o  (active_code)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  task automatic end_of_test();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [BUS_W-1:0] exp,
                     input logic [BUS_W-1:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [BUS_W-1:0] spread(
    input logic [NUM_CH-1:0] m, input logic [CODE_W-1:0] c);
    logic [BUS_W-1:0] v;
    v = '0;
    for (int n = 0; n < NUM_CH; n++) begin
      if (m[n]) begin
        v[n*CODE_W +: CODE_W] = c;
      end
    end
    return v;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    reg_wr_i    = 1'b1;
    reg_addr_i  = a;
    reg_wdata_i = d;
    @(negedge sys_clk_i);
    reg_wr_i = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge sys_clk_i);
    reg_rd_i   = 1'b1;
    reg_addr_i = a;
    @(negedge sys_clk_i);
    reg_rd_i = 1'b0;
    chk("read data", BUS_W'(exp), BUS_W'(reg_rdata_o));
  endtask

  // Write then read back in the very next cycle.
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
                       input logic [7:0] exp);
    @(negedge sys_clk_i);
    reg_wr_i    = 1'b1;
    reg_addr_i  = a;
    reg_wdata_i = d;
    @(negedge sys_clk_i);
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b1;
    @(negedge sys_clk_i);
    reg_rd_i = 1'b0;
    chk("read data", BUS_W'(exp), BUS_W'(reg_rdata_o));
  endtask

  // Strobes may show only in the second cycle after the write cycle.
  task automatic wr_strobe(input logic [7:0] a, input logic [7:0] d,
                           input logic [NUM_CH-1:0] stg,
                           input logic [NUM_CH-1:0] act);
    wr(a, d);
    chk("early strobes", '0, BUS_W'(strobes));
    @(negedge sys_clk_i);
    chk("strobes", BUS_W'({stg, act}), BUS_W'(strobes));
    @(negedge sys_clk_i);
    chk("late strobes", '0, BUS_W'(strobes));
  endtask

  task automatic test_reset_values();
    for (int a = 8'h32; a <= 8'h37; a++) begin
      rd(8'(a), 8'h00);
    end
    rd(8'h50, 8'h00);
  endtask

  // With no targets selected, broadcast writes must stay silent.
  task automatic test_access();
    wr_strobe(8'h35, 8'hFF, 6'h00, 6'h00);
    rd(8'h35, 8'hFC);
    wr_strobe(8'h32, 8'hFF, 6'h00, 6'h00);
    rd(8'h32, 8'hFC);
    wr(8'h34, 8'hFF);
    rd(8'h34, 8'h3F);
    wr(8'h34, 8'h00);
    wr_strobe(8'h37, 8'hC0, 6'h00, 6'h00);
    rd(8'h37, 8'h00);
  endtask

  task automatic test_staging_bcast();
    wr(8'h34, 8'h15);
    wr_strobe(8'h36, 8'hA5, 6'h15, 6'h00);
    chk("staging code", BUS_W'({8'hA5, 6'h3F}),
        BUS_W'(staging_wdata_o));
    wr_strobe(8'h35, 8'h48, 6'h15, 6'h00);
    chk("staging code", BUS_W'({8'hA5, 6'h12}),
        BUS_W'(staging_wdata_o));
  endtask

  task automatic test_transfer();
    wr_strobe(8'h37, 8'h05, 6'h00, 6'h05);
    chk("active codes", spread(6'h05, {8'hA5, 6'h12}),
        active_code);
    wr_strobe(8'h37, 8'h3F, 6'h00, 6'h3F);
    chk("active codes", spread(6'h15, {8'hA5, 6'h12}),
        active_code);
    rd(8'h37, 8'h00);
    wr_strobe(8'h37, 8'h00, 6'h00, 6'h00);
  endtask

  task automatic test_active_bcast();
    wr(8'h34, 8'h2A);
    wr_strobe(8'h33, 8'h5A, 6'h00, 6'h2A);
    chk("active codes", spread(6'h2A, {8'h5A, 6'h3F}) |
        spread(6'h15, {8'hA5, 6'h12}), active_code);
    rd(8'h33, 8'h5A);
    wr_rd(8'h34, 8'hC9, 8'h09);
    wr_rd(8'h33, 8'h3C, 8'h3C);
    chk("strobes", BUS_W'({6'h00, 6'h09}), BUS_W'(strobes));
    @(negedge sys_clk_i);
    chk("active codes", spread(6'h09, {8'h3C, 6'h3F}) |
        spread(6'h22, {8'h5A, 6'h3F}) | spread(6'h14, {8'hA5, 6'h12}),
        active_code);
    wr_strobe(8'h32, 8'h48, 6'h00, 6'h09);
    chk("active codes", spread(6'h09, {8'h3C, 6'h12}) |
        spread(6'h22, {8'h5A, 6'h3F}) | spread(6'h14, {8'hA5, 6'h12}),
        active_code);
    rd(8'h32, 8'h48);
  endtask

  // A reset in mid-run must clear every register, targets included.
  task automatic test_mid_reset();
    @(negedge sys_clk_i);
    rst_i = 1'b1;
    @(negedge sys_clk_i);
    rst_i = 1'b0;
    chk("active data", '0, active_wdata_o);
    chk("staging data", '0, BUS_W'(staging_wdata_o));
    for (int a = 8'h32; a <= 8'h37; a++) begin
      rd(8'(a), 8'h00);
    end
    wr_strobe(8'h36, 8'h81, 6'h00, 6'h00);
    chk("staging code", BUS_W'({8'h81, 6'h00}),
        BUS_W'(staging_wdata_o));
  endtask

  initial begin
    rst_i       = 1'b1;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    reg_addr_i  = 8'h00;
    reg_wdata_i = 8'h00;
    n_mismatch  = 0;
    tests_run   = 0;
    repeat (5) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rst_i = 1'b0;
    test_reset_values();
    test_access();
    test_staging_bcast();
    test_transfer();
    test_active_bcast();
    test_mid_reset();
    end_of_test();
  end

  // The sequence needs about 106 cycles; this bound is far beyond it.
  initial begin
    #20000;
    n_mismatch++;
    end_of_test();
  end
endmodule
